// *** shared/pcslc_pkg.sv ***
package pcslc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    // Printed offset is not a multiple of four, so it is a word index
    localparam int          CTRL_INDEX    = 32'h0000_0016;
    localparam int          STAT_INDEX    = 32'h0000_0017;
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  CTRL_ADDR     = 8'(CTRL_INDEX * 4);
    localparam logic [7:0]  STAT_ADDR     = 8'(STAT_INDEX * 4);

    localparam logic [15:0] CTRL_RESET    = 16'h0100;
    localparam logic [15:0] CTRL_WR_MASK  = 16'h1FFF;

    // Control field positions
    localparam int BIT_FREE_CLK           = 11;
    localparam int BIT_QUIET_TX           = 10;
    localparam int BIT_FORCED_SD          = 9;
    localparam int BIT_DETECT_OPTION      = 8;
    localparam int BIT_DESC_TIMEOUT       = 7;
    localparam int BIT_FORCE_GOOD         = 5;
    localparam int BIT_NRZI_BYPASS        = 2;

    // Status field positions
    localparam int STAT_LINK_GOOD         = 0;
    localparam int STAT_LINK_EVAL         = 1;
    localparam int STAT_SIGNAL            = 2;
    localparam int STAT_LOCK              = 3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS          = 10;
    localparam int DESC_SHORT_NS          = 722000;
    localparam int DESC_LONG_NS           = 2000000;
    localparam int DESC_SHORT_CYC         = DESC_SHORT_NS / CLK_PERIOD_NS;
    localparam int DESC_LONG_CYC          = DESC_LONG_NS / CLK_PERIOD_NS;
    localparam int TIMER_W                = 18;

    // ****************************************************************
    // Bus responses and states
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    typedef enum logic {
        LINK_DOWN,
        LINK_UP
    } pcslc_link_state_t;

endpackage

// *** hw/pcslc_pcs_link_control.sv ***
// Functional notes
// - Bits 15:13 ignore writes and always read back as zero.
// - Quiet-mode bit set puts 100 Mb/s transmitter into true quiet mode.
// - Forced-signal-detect bit makes the PMA report signal regardless of line.
// - Link rises only after valid signal level and descrambler lock together.
// - Option bit one: link held while signal valid; lock loss ignored.
// - Option bit zero: link held only while signal valid and lock kept.
// - Descrambler timeout is 722 us when bit clear, 2 ms when set.
// - Force-good-link bit reports a good 100 Mb/s link unconditionally.
// - Line-code bypass bit removes the NRZI encode/decode stage.
module pcslc_pcs_link_control
#(
    parameter int DESC_SHORT = pcslc_pkg::DESC_SHORT_CYC,
    parameter int DESC_LONG  = pcslc_pkg::DESC_LONG_CYC
) (
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_in,
    input  wire logic [pcslc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                      s_axi_awvalid_in,
    output logic                           s_axi_awready_out,
    input  wire logic [31:0]               s_axi_wdata_in,
    input  wire logic [3:0]                s_axi_wstrb_in,
    input  wire logic                      s_axi_wvalid_in,
    output logic                           s_axi_wready_out,
    output logic [1:0]                     s_axi_bresp_out,
    output logic                           s_axi_bvalid_out,
    input  wire logic                      s_axi_bready_in,
    input  wire logic [pcslc_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                      s_axi_arvalid_in,
    output logic                           s_axi_arready_out,
    output logic [31:0]                    s_axi_rdata_out,
    output logic [1:0]                     s_axi_rresp_out,
    output logic                           s_axi_rvalid_out,
    input  wire logic                      s_axi_rready_in,
    input  wire logic                      signal_level_valid_in,
    input  wire logic                      descrambler_lock_in,
    input  wire logic                      descrambler_activity_in,
    output logic                           quiet_transmit_enable_out,
    output logic                           forced_signal_detect_out,
    output logic                           signal_detect_out,
    output logic                           nrzi_bypass_out,
    output logic                           free_clk_out,
    output logic                           descrambler_timeout_out,
    output logic                           link_100_good_out
);
    import pcslc_pkg::*;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic                 aw_hold_reg, aw_hold_next;
    logic [ADDR_W-1:0]    aw_addr_reg, aw_addr_next;
    logic                 w_hold_reg, w_hold_next;
    logic [31:0]          w_data_reg, w_data_next;
    logic [3:0]           w_strb_reg, w_strb_next;
    logic                 bvalid_reg, bvalid_next;
    logic [1:0]           bresp_reg, bresp_next;
    logic                 rvalid_reg, rvalid_next;
    logic [31:0]          rdata_reg, rdata_next;
    logic [1:0]           rresp_reg, rresp_next;
    logic [15:0]          ctrl_reg, ctrl_next;
    logic                 aw_hs, w_hs, ar_hs, wr_fire;
    logic [ADDR_W-1:0]    wr_addr;
    logic [31:0]          wr_data;
    logic [3:0]           wr_strb;
    logic [15:0]          lane_mask;
    logic [15:0]          status_word;

    assign s_axi_awready_out = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready_out  = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready_out = !rvalid_reg;
    assign s_axi_bvalid_out  = bvalid_reg;
    assign s_axi_bresp_out   = bresp_reg;
    assign s_axi_rvalid_out  = rvalid_reg;
    assign s_axi_rdata_out   = rdata_reg;
    assign s_axi_rresp_out   = rresp_reg;

    assign aw_hs   = s_axi_awvalid_in && s_axi_awready_out;
    assign w_hs    = s_axi_wvalid_in && s_axi_wready_out;
    assign ar_hs   = s_axi_arvalid_in && s_axi_arready_out;
    // Address and data may arrive in either order
    assign wr_fire = (aw_hold_reg || aw_hs) && (w_hold_reg || w_hs);
    assign wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr_in;
    assign wr_data = w_hold_reg ? w_data_reg : s_axi_wdata_in;
    assign wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb_in;
    assign lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}}
                     & CTRL_WR_MASK;

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        ctrl_next    = ctrl_reg;
        if (aw_hs) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axi_awaddr_in;
        end
        if (w_hs) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata_in;
            w_strb_next = s_axi_wstrb_in;
        end
        if (bvalid_reg && s_axi_bready_in) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = RESP_OKAY;
            if (wr_addr == CTRL_ADDR) begin
                // Top three bits never take a write
                ctrl_next = (ctrl_reg & ~lane_mask)
                          | (wr_data[15:0] & lane_mask);
            end else if (wr_addr != STAT_ADDR) begin
                bresp_next = RESP_SLVERR;
            end
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && s_axi_rready_in) begin
            rvalid_next = 1'b0;
        end
        if (ar_hs) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            if (s_axi_araddr_in == CTRL_ADDR) begin
                rdata_next = {16'h0000, ctrl_reg & CTRL_WR_MASK};
            end else if (s_axi_araddr_in == STAT_ADDR) begin
                rdata_next = {16'h0000, status_word};
            end else begin
                rdata_next = 32'h0000_0000;
                rresp_next = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= RESP_OKAY;
            ctrl_reg    <= CTRL_RESET;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg  <= w_hold_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            ctrl_reg    <= ctrl_next;
        end
    end

    // ****************************************************************
    // Control outputs
    // ****************************************************************
    logic sd_eff;
    logic option_hold;

    assign quiet_transmit_enable_out = ctrl_reg[BIT_QUIET_TX];
    assign forced_signal_detect_out  = ctrl_reg[BIT_FORCED_SD];
    assign nrzi_bypass_out           = ctrl_reg[BIT_NRZI_BYPASS];
    assign free_clk_out              = ctrl_reg[BIT_FREE_CLK];
    // Forcing overrides whatever the line shows
    assign sd_eff = signal_level_valid_in || ctrl_reg[BIT_FORCED_SD];
    assign signal_detect_out = sd_eff;

    // ****************************************************************
    // Link evaluation
    // ****************************************************************
    pcslc_link_state_t link_reg, link_next;

    assign option_hold = ctrl_reg[BIT_DETECT_OPTION] ? sd_eff
                       : (sd_eff && descrambler_lock_in);

    always_comb begin
        link_next = link_reg;
        unique case (link_reg)
            LINK_DOWN: begin
                if (sd_eff && descrambler_lock_in) begin
                    link_next = LINK_UP;
                end
            end
            LINK_UP: begin
                if (!option_hold) begin
                    link_next = LINK_DOWN;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_reg <= LINK_DOWN;
        end else begin
            link_reg <= link_next;
        end
    end

    // Forcing good link overrides link_100_good_out only; link_reg still evaluates
    assign link_100_good_out = (link_reg == LINK_UP)
                             || ctrl_reg[BIT_FORCE_GOOD];

    assign status_word = {12'h000, descrambler_lock_in, sd_eff,
                          link_reg == LINK_UP, link_100_good_out};

    // ****************************************************************
    // Descrambler timeout
    // ****************************************************************
    // Runs only while locked; activity restarts it
    logic [TIMER_W-1:0] dtimer_reg, dtimer_next;
    logic               dto_reg, dto_next;
    logic [TIMER_W-1:0] dlimit;
    logic               dexpire;

    assign dlimit = ctrl_reg[BIT_DESC_TIMEOUT]
                  ? TIMER_W'(DESC_LONG - 1)
                  : TIMER_W'(DESC_SHORT - 1);
    assign dexpire = descrambler_lock_in && !descrambler_activity_in
                   && (dtimer_reg >= dlimit);

    always_comb begin
        dto_next = dexpire;
        if (!descrambler_lock_in || descrambler_activity_in || dexpire) begin
            dtimer_next = '0;
        end else begin
            dtimer_next = dtimer_reg + TIMER_W'(1);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dtimer_reg <= '0;
            dto_reg    <= 1'b0;
        end else begin
            dtimer_reg <= dtimer_next;
            dto_reg    <= dto_next;
        end
    end

    assign descrambler_timeout_out = dto_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_top_bits_zero: assert property (
        s_axi_rvalid_out |-> s_axi_rdata_out[15:13] == 3'h0)
        else $error("Reserved top bits read non-zero");

    a_quiet_follows: assert property (
        wr_fire && wr_addr == CTRL_ADDR && wr_strb[1]
        |=> quiet_transmit_enable_out == $past(wr_data[BIT_QUIET_TX]))
        else $error("Quiet mode did not follow write");

    a_forced_detect: assert property (
        forced_signal_detect_out |-> signal_detect_out)
        else $error("Forced detect not reported");

    a_rise_needs_both: assert property (
        $rose(link_reg == LINK_UP)
        |-> $past(sd_eff) && $past(descrambler_lock_in))
        else $error("Link rose without signal and lock");

    a_option_keeps: assert property (
        link_reg == LINK_UP && ctrl_reg[BIT_DETECT_OPTION] && sd_eff
        |=> link_reg == LINK_UP)
        else $error("Link dropped with valid signal");

    a_option_drops: assert property (
        link_reg == LINK_UP && !ctrl_reg[BIT_DETECT_OPTION]
        && !descrambler_lock_in |=> link_reg == LINK_DOWN)
        else $error("Link kept after lock loss");

    a_timeout_count: assert property (
        descrambler_timeout_out |-> $past(dtimer_reg) == $past(dlimit))
        else $error("Timeout at wrong count");

    a_force_good: assert property (
        wr_fire && wr_addr == CTRL_ADDR && wr_strb[0]
        && wr_data[BIT_FORCE_GOOD] |=> link_100_good_out)
        else $error("Forced good link not reported");

    a_bypass_out: assert property (
        wr_fire && wr_addr == CTRL_ADDR && wr_strb[0]
        |=> nrzi_bypass_out == $past(wr_data[BIT_NRZI_BYPASS]))
        else $error("Bypass output did not follow write");

    c_link_up:    cover property ($rose(link_reg == LINK_UP));
    c_lock_keep:  cover property (link_reg == LINK_UP && !descrambler_lock_in
                                  ##1 link_reg == LINK_UP);
    c_timeout:    cover property (descrambler_timeout_out);
    c_write_ctrl: cover property (wr_fire && wr_addr == CTRL_ADDR);

endmodule

// *** test/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcslc_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam int T_SHORT = 20;
    localparam int T_LONG  = 50;
    logic        ref_clk_in = 1'b0;
    logic        rst_in     = 1'b1;
    logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in  = 32'h0;
    logic [3:0]  s_axi_wstrb_in  = 4'h0;
    logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic        s_axi_bready_in  = 1'b0, s_axi_arvalid_in = 1'b0;
    logic        s_axi_rready_in  = 1'b0;
    logic        signal_level_valid_in = 1'b0, descrambler_lock_in = 1'b0;
    logic        descrambler_activity_in = 1'b1;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic        s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out;
    logic        quiet_transmit_enable_out, forced_signal_detect_out;
    logic        signal_detect_out, nrzi_bypass_out, free_clk_out;
    logic        descrambler_timeout_out, link_100_good_out;
    int          n_mismatch = 0;
    int          comparisons = 0;

    always #5 ref_clk_in = ~ref_clk_in;

    pcslc_pcs_link_control #(.DESC_SHORT(T_SHORT), .DESC_LONG(T_LONG))
        pcslc_pcs_link_control_i (
        .ref_clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
        .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
        .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
        .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
        .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
        .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
        .signal_level_valid_in, .descrambler_lock_in,
        .descrambler_activity_in, .quiet_transmit_enable_out,
        .forced_signal_detect_out, .signal_detect_out, .nrzi_bypass_out,
        .free_clk_out, .descrambler_timeout_out, .link_100_good_out);

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic finish_test();
        $display("counts: %0d mismatches, %0d comparisons",
                 n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Handshakes sampled mid-cycle; ready only moves at rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] exp_resp);
        bit aw_hs, w_hs, b_hs, done;
        int t;
        done = 0;
        t = 0;
        @(posedge ref_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wdata_in <= d;
        s_axi_wstrb_in <= s;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        while (!done && t < 100) begin
            @(negedge ref_clk_in);
            aw_hs = s_axi_awvalid_in && s_axi_awready_out;
            w_hs = s_axi_wvalid_in && s_axi_wready_out;
            b_hs = s_axi_bready_in && s_axi_bvalid_out;
            if (b_hs) cmp(32'(s_axi_bresp_out), 32'(exp_resp));
            @(posedge ref_clk_in);
            if (aw_hs) s_axi_awvalid_in <= 1'b0;
            if (w_hs) s_axi_wvalid_in <= 1'b0;
            if (b_hs) s_axi_bready_in <= 1'b0;
            done = b_hs;
            t++;
        end
        if (!done) cmp(32'h0, 32'h1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp_d,
                          input logic [1:0] exp_resp);
        bit ar_hs, done;
        int t;
        done = 0;
        t = 0;
        @(posedge ref_clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        while (!done && t < 100) begin
            @(negedge ref_clk_in);
            ar_hs = s_axi_arvalid_in && s_axi_arready_out;
            done = s_axi_rready_in && s_axi_rvalid_out;
            if (done) cmp(s_axi_rdata_out, exp_d);
            if (done) cmp(32'(s_axi_rresp_out), 32'(exp_resp));
            @(posedge ref_clk_in);
            if (ar_hs) s_axi_arvalid_in <= 1'b0;
            if (done) s_axi_rready_in <= 1'b0;
            t++;
        end
        if (!done) cmp(32'h0, 32'h1);
    endtask

    // Line inputs, then let the link state settle before looking
    task automatic line(input logic sig, input logic lock);
        @(posedge ref_clk_in);
        signal_level_valid_in <= sig;
        descrambler_lock_in <= lock;
        repeat (3) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask

    task automatic timeout_len(input int lim);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        descrambler_lock_in <= 1'b1;
        descrambler_activity_in <= 1'b0;
        do begin
            @(negedge ref_clk_in);
            n++;
        end while (descrambler_timeout_out !== 1'b1 && n < 300);
        cmp(32'(n), 32'(lim + 1));
        @(posedge ref_clk_in);
        descrambler_activity_in <= 1'b1;
        descrambler_lock_in <= 1'b0;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        int bits[5] = '{BIT_QUIET_TX, BIT_FORCED_SD, BIT_NRZI_BYPASS,
                        BIT_FORCE_GOOD, BIT_FREE_CLK};
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd_chk(CTRL_ADDR, 32'h0000_0100, RESP_OKAY);
        @(negedge ref_clk_in);
        cmp(32'(link_100_good_out), 32'h0);
        $display("test reset done");

        // Reserved bits kept at zero; top bits set to prove they are dropped
        wr(CTRL_ADDR, 32'hFFFF_EFA4, 4'hF, RESP_OKAY);
        rd_chk(CTRL_ADDR, 32'h0000_0FA4, RESP_OKAY);
        wr(CTRL_ADDR, 32'h0000_0000, 4'h1, RESP_OKAY);
        rd_chk(CTRL_ADDR, 32'h0000_0F00, RESP_OKAY);
        wr(8'h60, 32'h0000_0020, 4'hF, RESP_SLVERR);
        rd_chk(8'h60, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 5; i++) begin
            wr(CTRL_ADDR, 32'h1 << bits[i], 4'h3, RESP_OKAY);
            @(negedge ref_clk_in);
            cmp(32'({quiet_transmit_enable_out, forced_signal_detect_out,
                 nrzi_bypass_out, link_100_good_out, free_clk_out}),
                32'(5'h10 >> i));
        end
        $display("test register fields done");

        wr(CTRL_ADDR, 32'h0000_0100, 4'h3, RESP_OKAY);
        line(1'b1, 1'b0);
        cmp(32'(link_100_good_out), 32'h0);
        line(1'b1, 1'b1);
        cmp(32'(link_100_good_out), 32'h1);
        rd_chk(STAT_ADDR, 32'h0000_000F, RESP_OKAY);
        line(1'b1, 1'b0);
        cmp(32'(link_100_good_out), 32'h1);
        line(1'b0, 1'b0);
        cmp(32'(link_100_good_out), 32'h0);
        wr(CTRL_ADDR, 32'h0000_0000, 4'h3, RESP_OKAY);
        line(1'b1, 1'b1);
        cmp(32'(link_100_good_out), 32'h1);
        line(1'b1, 1'b0);
        cmp(32'(link_100_good_out), 32'h0);
        line(1'b0, 1'b0);
        wr(CTRL_ADDR, 32'h0000_0200, 4'h3, RESP_OKAY);
        line(1'b0, 1'b1);
        cmp(32'(signal_detect_out), 32'h1);
        cmp(32'(link_100_good_out), 32'h1);
        line(1'b0, 1'b0);
        $display("test link evaluation done");

        wr(CTRL_ADDR, 32'h0000_0100, 4'h3, RESP_OKAY);
        timeout_len(T_SHORT);
        wr(CTRL_ADDR, 32'h0000_0180, 4'h3, RESP_OKAY);
        timeout_len(T_LONG);
        $display("test descrambler timeout done");

        // Reset in mid-run must bring back the reset value
        rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd_chk(CTRL_ADDR, 32'h0000_0100, RESP_OKAY);
        @(negedge ref_clk_in);
        cmp(32'(link_100_good_out), 32'h0);
        cmp(32'(descrambler_timeout_out), 32'h0);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule
